// ### ptm_timers.sv
// Prescalers S and W with timer A and timer B of a small controller.
// Assumes one clock, a 4-bit register port with read data one cycle later,
// and the 32 kHz oscillator and event pins arriving asynchronously.
`timescale 1ns/10ps
`default_nettype none
`include "ptm_map.svh"
module ptm_timers
  import ptm_pkg::*;
#(
  parameter int PSS_W = `PTM_PSS_W,
  parameter int PSW_W = `PTM_PSW_W
) (
  // Clock, reset, freeze
  input  wire logic           ref_clk,
  input  wire logic           rstn,
  input  wire logic           clkEn,
  // Controller state
  input  wire ptm_opmode_type opMode,
  // Register port
  input  wire ptm_busreq_type busReq,
  output logic [3:0]          rdData,
  // Pins
  input  wire logic           subclkPin,
  input  wire logic           timerBEventPin,
  output logic                timerBOutputPin,
  output logic                timerBOutputEn,
  // Interrupt request flags
  output logic                timerAIrqFlag,
  output logic                timerBIrqFlag
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // Tap of prescaler S for a 3-bit select; smaller select, slower clock
  function automatic logic [3:0] tapOfSys(input logic [2:0] sel);
    logic [3:0] idx;
    idx = 4'h0;
    case (sel)
      3'h0:    idx = 4'ha;
      3'h1:    idx = 4'h9;
      3'h2:    idx = 4'h7;
      3'h3:    idx = 4'h5;
      3'h4:    idx = 4'h3;
      3'h5:    idx = 4'h2;
      3'h6:    idx = 4'h1;
      default: idx = 4'h0;
    endcase
    return idx;
  endfunction : tapOfSys

  // Tap of prescaler W for a 3-bit select in time-base use
  function automatic logic [3:0] tapOfSub(input logic [2:0] sel);
    logic [3:0] idx;
    idx = 4'h0;
    case (sel)
      3'h0:    idx = 4'h7;
      3'h1:    idx = 4'h6;
      3'h2:    idx = 4'h5;
      3'h3:    idx = 4'h4;
      3'h4:    idx = 4'h3;
      3'h5:    idx = 4'h2;
      3'h6:    idx = 4'h1;
      default: idx = 4'h0;
    endcase
    return idx;
  endfunction : tapOfSub

  // True when the divider's increment carries out of the tap bit
  function automatic logic tapHit(input logic [15:0] cnt, input logic [3:0] idx);
    logic [15:0] mask;
    mask = ~(16'hfffe << idx);
    return (cnt & mask) == mask;
  endfunction : tapHit

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [PSS_W-1:0]               sysDiv_ff;
  logic [PSW_W-1:0]               subDiv_ff;
  logic [`PTM_SUB_PREDIV_W-1:0]   subPre_ff;
  logic [3:0]                     tmaMode_ff;
  logic [3:0]                     tmb1Mode_ff;
  logic [2:0]                     tmb2Mode_ff;
  logic [3:0]                     pinFn2_ff;
  logic [7:0]                     timerA_ff;
  logic [7:0]                     timerB_ff;
  logic [3:0]                     loadLow_ff;
  logic [3:0]                     loadHigh_ff;
  logic [7:0]                     duty_ff;
  logic [3:0]                     snapLow_ff;
  logic                           toggle_ff;
  ptm_pinev_type                  subEv;
  ptm_pinev_type                  evtEv;
  logic                           wrHit;
  logic                           rdHit;
  logic                           sysInc;
  logic                           subTick;
  logic                           subInc;
  logic                           subClear;
  logic                           tickA;
  logic                           tickB;
  logic                           ovfA;
  logic                           ovfB;
  logic                           evtEdge;
  logic                           loadHighWr;
  ptm_outmode_type                outMode;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  ptm_pin_sync u_subSync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clkEn   (clkEn),
    .pinIn   (subclkPin),
    .pinEv   (subEv)
  );

  ptm_pin_sync u_evtSync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clkEn   (clkEn),
    .pinIn   (timerBEventPin),
    .pinEv   (evtEv)
  );

  // --------------------------------------------------------------------------
  // Count enables
  // --------------------------------------------------------------------------

  // Bus strobes are qualified here so every write site sees one term
  assign wrHit = busReq.wrStb;
  assign rdHit = busReq.rdStb;

  // Subclock ticks once per eight oscillator rises; stops only in stop mode
  assign subTick = subEv.rise && (subPre_ff == `PTM_SUB_PREDIV_W'(`PTM_SUB_PREDIV - 1));
  assign subInc  = subTick && (opMode != OPM_STOP);

  // System divider input follows the operating mode
  always_comb begin
    case (opMode)
      OPM_ACTIVE, OPM_STANDBY: sysInc = 1'b1;
      OPM_SUBACTIVE:           sysInc = subTick;
      default:                 sysInc = 1'b0;
    endcase
  end

  // All ones in mode bits 3..1 asks for a divider and timer A clear
  assign subClear = wrHit && (busReq.addr == `PTM_ADDR_TMA)
                    && (busReq.wrData[3:1] == 3'h7);

  // Timer A source: prescaler W tap in time-base use, else prescaler S tap
  assign tickA = tmaMode_ff[`PTM_TMA_TB_BIT]
               ? (subInc && tapHit(16'(subDiv_ff), tapOfSub(tmaMode_ff[2:0])))
               : (sysInc && tapHit(16'(sysDiv_ff), tapOfSys(tmaMode_ff[2:0])));
  assign ovfA  = tickA && (timerA_ff == 8'hff);

  // Event edge selection; the far end must space edges in both-edge use
  always_comb begin
    case (ptm_edge_type'(tmb2Mode_ff[1:0]))
      EDGE_FALL: evtEdge = evtEv.fall;
      EDGE_RISE: evtEdge = evtEv.rise;
      default:   evtEdge = evtEv.fall | evtEv.rise;
    endcase
  end

  // Timer B source: event pin when select is zero, else prescaler S tap
  assign tickB = (tmb1Mode_ff[2:0] == 3'h0)
               ? (evtEdge && pinFn2_ff[`PTM_PF2_EVT_BIT])
               : (sysInc && tapHit(16'(sysDiv_ff), tapOfSys(tmb1Mode_ff[2:0])));
  assign ovfB  = tickB && (timerB_ff == 8'hff);

  assign outMode    = ptm_outmode_type'(tmb2Mode_ff[`PTM_TIMER_B_MODE_REG2_PWM_BIT]);
  assign loadHighWr = wrHit && (busReq.addr == `PTM_ADDR_TB_HIGH);

  // --------------------------------------------------------------------------
  // Prescalers
  // --------------------------------------------------------------------------

  // Prescaler S runs free whenever its mode allows
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sysDiv_ff <= '0;
    end else if (clkEn && sysInc) begin
      sysDiv_ff <= sysDiv_ff + 1'b1;
    end
  end

  // Divide-by-eight in front of prescaler W
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      subPre_ff <= '0;
    end else if (clkEn && subEv.rise) begin
      subPre_ff <= subPre_ff + 1'b1;
    end
  end

  // Prescaler W; a software clear beats a tick in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      subDiv_ff <= '0;
    end else if (clkEn) begin
      if (subClear) begin
        subDiv_ff <= '0;
      end else if (subInc) begin
        subDiv_ff <= subDiv_ff + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Mode and pin-function registers (write-only)
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tmaMode_ff  <= `PTM_RST_NIBBLE;
      tmb1Mode_ff <= `PTM_RST_NIBBLE;
      tmb2Mode_ff <= 3'h0;
      pinFn2_ff   <= `PTM_RST_NIBBLE;
    end else if (clkEn && wrHit) begin
      case (busReq.addr)
        `PTM_ADDR_TMA:    tmaMode_ff  <= busReq.wrData;
        `PTM_ADDR_TIMER_B_MODE_REG1:   tmb1Mode_ff <= busReq.wrData;
        `PTM_ADDR_TIMER_B_MODE_REG2:   tmb2Mode_ff <= busReq.wrData[2:0];
        `PTM_ADDR_PINFN2: pinFn2_ff   <= busReq.wrData;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Timer A
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      timerA_ff <= 8'h00;
    end else if (clkEn) begin
      if (subClear) begin
        timerA_ff <= 8'h00;
      end else if (tickA) begin
        timerA_ff <= timerA_ff + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt request flags; a set in the clearing cycle wins
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      timerAIrqFlag <= 1'b0;
      timerBIrqFlag <= 1'b0;
    end else if (clkEn) begin
      if (ovfA) begin
        timerAIrqFlag <= 1'b1;
      end else if (wrHit && busReq.addr == `PTM_ADDR_IRQ
                   && busReq.wrData[`PTM_IRQ_A_BIT]) begin
        timerAIrqFlag <= 1'b0;
      end
      if (ovfB) begin
        timerBIrqFlag <= 1'b1;
      end else if (wrHit && busReq.addr == `PTM_ADDR_IRQ
                   && busReq.wrData[`PTM_IRQ_B_BIT]) begin
        timerBIrqFlag <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Timer B load registers
  // --------------------------------------------------------------------------

  // Low nibble only stores; the counter waits for the high nibble
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      loadLow_ff  <= `PTM_RST_NIBBLE;
      loadHigh_ff <= `PTM_RST_NIBBLE;
    end else if (clkEn && wrHit) begin
      if (busReq.addr == `PTM_ADDR_TB_LOW) begin
        loadLow_ff <= busReq.wrData;
      end
      if (busReq.addr == `PTM_ADDR_TB_HIGH) begin
        loadHigh_ff <= busReq.wrData;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Timer B counter
  // --------------------------------------------------------------------------

  // PWM frames always span the full 256 counts, so the duty value never
  // moves the frame start except on an immediate-update write
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      timerB_ff <= 8'h00;
    end else if (clkEn) begin
      if (loadHighWr) begin
        if (outMode == OUT_PWM) begin
          if (tmb1Mode_ff[`PTM_TIMER_B_MODE_REG1_RLD_BIT]) begin
            timerB_ff <= 8'h00;
          end
        end else begin
          timerB_ff <= {busReq.wrData, loadLow_ff};
        end
      end else if (ovfB) begin
        if (outMode == OUT_TOGGLE && tmb1Mode_ff[`PTM_TIMER_B_MODE_REG1_RLD_BIT]) begin
          timerB_ff <= {loadHigh_ff, loadLow_ff};
        end else begin
          timerB_ff <= 8'h00;
        end
      end else if (tickB) begin
        timerB_ff <= timerB_ff + 8'h01;
      end
    end
  end

  // Duty value: taken at frame end, or at once when the update bit is set
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      duty_ff <= 8'h00;
    end else if (clkEn) begin
      if (loadHighWr && tmb1Mode_ff[`PTM_TIMER_B_MODE_REG1_RLD_BIT]) begin
        duty_ff <= {busReq.wrData, loadLow_ff};
      end else if (ovfB) begin
        duty_ff <= {loadHigh_ff, loadLow_ff};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Timer B output
  // --------------------------------------------------------------------------

  // Toggle state flips on the clock that overflows the counter
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      toggle_ff <= 1'b0;
    end else if (clkEn && ovfB) begin
      toggle_ff <= ~toggle_ff;
    end
  end

  // Pin level and enable come from flops; PWM lags the counter one cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      timerBOutputPin <= 1'b0;
      timerBOutputEn  <= 1'b0;
    end else if (clkEn) begin
      timerBOutputEn <= pinFn2_ff[`PTM_PF2_OUT_BIT];
      if (outMode == OUT_PWM) begin
        timerBOutputPin <= (timerB_ff < duty_ff);
      end else begin
        timerBOutputPin <= toggle_ff;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read path: data stand in the cycle after the strobe only
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      snapLow_ff <= 4'h0;
    end else if (clkEn && rdHit && busReq.addr == `PTM_ADDR_TB_HIGH) begin
      snapLow_ff <= timerB_ff[3:0];
    end
  end

  // Write-only and unmapped locations read as zero
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdData <= 4'h0;
    end else if (clkEn) begin
      rdData <= 4'h0;
      if (rdHit) begin
        case (busReq.addr)
          `PTM_ADDR_TB_HIGH: rdData <= timerB_ff[7:4];
          `PTM_ADDR_TB_LOW:  rdData <= snapLow_ff;
          `PTM_ADDR_IRQ:     rdData <= {1'b0, timerBIrqFlag, 1'b0, timerAIrqFlag};
          default:           rdData <= 4'h0;
        endcase
      end
    end
  end

endmodule : ptm_timers
`default_nettype wire

// ### ptm_map.svh
// Register map, field positions, reset values and counts for the prescaler and timers A/B.
// Assumes a 4-bit register port with an 8-bit address and one 100 MHz clock.
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PTM_ADDR_W        8
`define PTM_DATA_W        4
`define PTM_ADDR_IRQ      8'h02
`define PTM_ADDR_PINFN2   8'h0a
`define PTM_ADDR_TMA      8'h0f
`define PTM_ADDR_TIMER_B_MODE_REG1     8'h10
`define PTM_ADDR_TIMER_B_MODE_REG2     8'h11
`define PTM_ADDR_TB_LOW   8'h12
`define PTM_ADDR_TB_HIGH  8'h13

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PTM_IRQ_A_BIT     0
`define PTM_IRQ_B_BIT     2
`define PTM_TMA_TB_BIT    3
`define PTM_TIMER_B_MODE_REG1_RLD_BIT  3
`define PTM_TIMER_B_MODE_REG2_PWM_BIT  2
`define PTM_PF2_EVT_BIT   0
`define PTM_PF2_OUT_BIT   3

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define PTM_RST_NIBBLE    4'h0
`define PTM_PSS_W         11
`define PTM_PSW_W         8
`define PTM_SUB_PREDIV    8
`define PTM_SUB_PREDIV_W  3
`define PTM_TAP_W         4
`define PTM_TAP_CNT_W     16

`endif

// ### ptm_pkg.sv
// Types shared by the prescaler/timer block and its pin synchroniser.
// Assumes the constants of ptm_map.svh are included by the users.
package ptm_pkg;

  // --------------------------------------------------------------------------
  // Operating modes of the surrounding controller
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OPM_ACTIVE    = 3'b000,
    OPM_STANDBY   = 3'b001,
    OPM_SUBACTIVE = 3'b010,
    OPM_WATCH     = 3'b011,
    OPM_STOP      = 3'b100
  } ptm_opmode_type;

  // --------------------------------------------------------------------------
  // Event edge selection and output waveform
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_FALL  = 2'b00,
    EDGE_RISE  = 2'b01,
    EDGE_BOTH  = 2'b10,
    EDGE_BOTHX = 2'b11
  } ptm_edge_type;

  typedef enum logic {
    OUT_TOGGLE = 1'b0,
    OUT_PWM    = 1'b1
  } ptm_outmode_type;

  // --------------------------------------------------------------------------
  // Register port request
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] wrData;
    logic       wrStb;
    logic       rdStb;
  } ptm_busreq_type;

  // Edge report of a synchronised pin
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } ptm_pinev_type;

endpackage : ptm_pkg

// ### ptm_pin_sync.sv
// Three-stage pin synchroniser with filtered level and edge pulses.
// Assumes an asynchronous pin; a change is taken once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module ptm_pin_sync
  import ptm_pkg::*;
(
  // Clock and reset
  input  wire logic     ref_clk,
  input  wire logic     rstn,
  input  wire logic     clkEn,
  // Pin and result
  input  wire logic     pinIn,
  output ptm_pinev_type pinEv
);

  logic [2:0] stage_ff;
  logic       level_ff;
  logic       rise_ff;
  logic       fall_ff;

  // Shift chain; stage 0 is only read by stage 1
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stage_ff <= 3'h0;
    end else if (clkEn) begin
      stage_ff <= {stage_ff[1:0], pinIn};
    end
  end

  // Accept a new level only when the two later stages agree
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
      fall_ff  <= 1'b0;
    end else if (clkEn) begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
      if (stage_ff[1] == stage_ff[2] && stage_ff[2] != level_ff) begin
        level_ff <= stage_ff[2];
        rise_ff  <= stage_ff[2];
        fall_ff  <= ~stage_ff[2];
      end
    end
  end

  assign pinEv = '{level: level_ff, rise: rise_ff, fall: fall_ff};

endmodule : ptm_pin_sync
`default_nettype wire

// ### ptm_checker.sv
// Port checker for the prescaler and timers A/B, bound into the top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module ptm_checker
  import ptm_pkg::*;
#(
  parameter int PSS_W = 11,
  parameter int PSW_W = 8
) (
  // Clock, reset, freeze
  input wire logic           ref_clk,
  input wire logic           rstn,
  input wire logic           clkEn,
  // Controller state and register port
  input wire ptm_opmode_type opMode,
  input wire ptm_busreq_type busReq,
  input wire logic [3:0]     rdData,
  // Pins and flags
  input wire logic           subclkPin,
  input wire logic           timerBEventPin,
  input wire logic           timerBOutputPin,
  input wire logic           timerBOutputEn,
  input wire logic           timerAIrqFlag,
  input wire logic           timerBIrqFlag
);
  logic pwmMode_ff;
  default clocking dc @(posedge ref_clk); endclocking
  // A frozen block proves nothing, so frozen cycles are skipped
  default disable iff (!rstn || !clkEn);
  // ---------------------------------------------------------------------------
  // Waveform mode shadow, so toggles can be told from PWM edges
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) pwmMode_ff <= 1'b0;
    else if (clkEn && busReq.wrStb && busReq.addr == 8'h11) pwmMode_ff <= busReq.wrData[2];
  end
  a_rd_idle_zero: assert property (!busReq.rdStb |=> rdData == 4'h0)
    else $error("read data not idle");
  a_wo_read_zero: assert property (busReq.rdStb && busReq.addr inside {8'h0a, 8'h0f, 8'h10,
    8'h11} |=> rdData == 4'h0) else $error("write-only place read back");
  a_irq_read: assert property (busReq.rdStb && busReq.addr == 8'h02 |=> rdData[0] ==
    $past(timerAIrqFlag) && rdData[2] == $past(timerBIrqFlag)) else $error("flag read");
  a_irqb_sticky: assert property (timerBIrqFlag && !(busReq.wrStb && busReq.addr == 8'h02
    && busReq.wrData[2]) |=> timerBIrqFlag) else $error("timer B flag dropped");
  a_irqa_sticky: assert property (timerAIrqFlag && !(busReq.wrStb && busReq.addr == 8'h02
    && busReq.wrData[0]) |=> timerAIrqFlag) else $error("timer A flag dropped");
  // Enable follows the pin-function flop, so it trails the write by two edges
  a_oe_follow: assert property (busReq.wrStb && busReq.addr == 8'h0a |=> ##1
    timerBOutputEn == $past(busReq.wrData[3], 2)) else $error("output enable wrong");
  a_stop_freeze: assert property (opMode == OPM_STOP [*3] |=> !$rose(timerAIrqFlag))
    else $error("timer A ran in stop");
  // Pin lags the mode by one edge, so two past cycles of toggle mode are needed
  a_toggle_ovf: assert property (!pwmMode_ff && !$past(pwmMode_ff) && !$past(pwmMode_ff, 2)
    && $changed(timerBOutputPin) |-> timerBIrqFlag || $past(timerBIrqFlag))
    else $error("toggle without overflow");
  // Freeze is checked on its own, outside the default disable
  a_freeze_hold: assert property (disable iff (!rstn) !clkEn |=>
    $stable({rdData, timerBOutputPin, timerBOutputEn, timerAIrqFlag, timerBIrqFlag}))
    else $error("outputs moved while frozen");
endmodule : ptm_checker
bind ptm_timers ptm_checker #(.PSS_W(PSS_W), .PSW_W(PSW_W)) i_ptm_checker (
  .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .opMode(opMode), .busReq(busReq),
  .rdData(rdData), .subclkPin(subclkPin), .timerBEventPin(timerBEventPin),
  .timerBOutputPin(timerBOutputPin), .timerBOutputEn(timerBOutputEn),
  .timerAIrqFlag(timerAIrqFlag), .timerBIrqFlag(timerBIrqFlag));
`default_nettype wire

// ### ptm_evsrc.sv
// Far-side model: event pin source and a fast stand-in for the 32 kHz oscillator.
// Assumes the bench calls pulses() from its main sequence.
`timescale 1ns/10ps
`default_nettype none
module ptm_evsrc (
  // Clock
  input  wire logic ref_clk,
  // Pins towards the block
  output logic      evPin,
  output logic      subclk
);
  logic [1:0] divCnt = 2'h0;
  initial evPin = 1'b0;
  initial subclk = 1'b0;
  // Oscillator runs free; scaled down so a short run still sees divider ticks
  always @(posedge ref_clk) begin
    divCnt <= divCnt + 2'h1;
    if (divCnt == 2'h3) subclk <= ~subclk;
  end
  // Full pulses, each phase far longer than the synchroniser needs
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (20) @(posedge ref_clk);
      evPin <= 1'b1;
      repeat (20) @(posedge ref_clk);
      evPin <= 1'b0;
    end
    repeat (10) @(posedge ref_clk);
  endtask : pulses
endmodule : ptm_evsrc
`default_nettype wire

// ### tb.sv
// Self-checking bench for the prescaler and timers A/B.
// Assumes the event source model and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
module tb
  import ptm_pkg::*;
;
  logic           ref_clk = 1'b0;
  logic           rstn    = 1'b0;
  logic           clkEn   = 1'b1;
  ptm_opmode_type opMode  = OPM_ACTIVE;
  ptm_busreq_type busReq  = '0;
  logic [3:0]     rdData, hi, lo;
  logic           subclkPin, timerBEventPin, timerBOutputPin;
  logic           timerBOutputEn, timerAIrqFlag, timerBIrqFlag;
  logic [15:0]    rnd = 16'h7e9f;
  logic [7:0]     val;
  int             bad_count = 0;
  int             total_checks = 0;
  int             ones;
  always #5 ref_clk = ~ref_clk;
  ptm_timers #(.PSS_W(11), .PSW_W(8)) i_ptm_timers (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .opMode(opMode), .busReq(busReq),
    .rdData(rdData), .subclkPin(subclkPin), .timerBEventPin(timerBEventPin),
    .timerBOutputPin(timerBOutputPin), .timerBOutputEn(timerBOutputEn),
    .timerAIrqFlag(timerAIrqFlag), .timerBIrqFlag(timerBIrqFlag));
  ptm_evsrc i_ptm_evsrc (.ref_clk(ref_clk), .evPin(timerBEventPin), .subclk(subclkPin));
  // ---------------------------------------------------------------------------
  // Expectations, bus cycles and comparisons
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] nextRnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nextRnd
  // Both-edge codes see two edges per pulse
  function automatic logic [7:0] expEvents(input logic [1:0] e, input int n);
    return 8'(e[1] ? 2 * n : n);
  endfunction : expEvents
  // From FE, three clocks: reload gives FF,FE,FF and free-running FF,00,01
  function automatic logic [7:0] expWrap(input int m);
    return (m != 0) ? 8'hff : 8'h01;
  endfunction : expWrap
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge ref_clk);
    busReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge ref_clk);
    busReq.wrStb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [3:0] v);
    @(posedge ref_clk);
    busReq <= '{addr: a, wrData: 4'h0, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge ref_clk);
    busReq.rdStb <= 1'b0;
    #1 v = rdData;
  endtask : rd
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chkBit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chkBit
  // Bounded wait, so a dead timer cannot hang the run
  task automatic waitA(input int lim);
    for (int i = 0; i < lim && timerAIrqFlag !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask : waitA
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Watchdog sized well past the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    $display("ERROR watchdog expected done seen hung");
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    #1 chk("resetOuts", 8'h00, {4'h0, timerBOutputPin, timerBOutputEn, timerAIrqFlag,
      timerBIrqFlag});
    wr(8'h0f, 4'hf);
    wr(8'h0f, 4'h7);
    repeat (440) @(posedge ref_clk);
    #1 chkBit("irqAEarly", 1'b0, timerAIrqFlag);
    waitA(150);
    chkBit("irqA", 1'b1, timerAIrqFlag);
    wr(8'h02, 4'h1);
    @(posedge ref_clk);
    opMode <= OPM_STOP;
    repeat (300) @(posedge ref_clk);
    opMode <= OPM_WATCH;
    repeat (300) @(posedge ref_clk);
    opMode <= OPM_ACTIVE;
    #1 chkBit("irqAStop", 1'b0, timerAIrqFlag);
    waitA(600);
    chkBit("irqAResume", 1'b1, timerAIrqFlag);
    wr(8'h0f, 4'h0);
    wr(8'h02, 4'h1);
    $display("test timerA done");
    for (int k = 0; k < 5; k++) begin
      rnd = nextRnd(rnd);
      val = (k == 0) ? 8'hff : rnd[7:0];
      wr(8'h12, val[3:0]);
      wr(8'h13, val[7:4]);
      wr(8'h12, ~val[3:0]);
      rd(8'h13, hi);
      rd(8'h12, lo);
      chk("snapshot", val, {hi, lo});
      rd(8'h0f, hi);
      rd(8'h20, lo);
      chk("noReadback", 8'h00, {hi, lo});
    end
    $display("test load done");
    wr(8'h0a, 4'h9);
    for (int e = 0; e < 4; e++) begin
      rnd = nextRnd(rnd);
      wr(8'h11, e[3:0]);
      wr(8'h12, 4'h0);
      wr(8'h13, 4'h0);
      i_ptm_evsrc.pulses(2 + rnd[1:0]);
      rd(8'h13, hi);
      rd(8'h12, lo);
      chk("events", expEvents(e[1:0], 2 + rnd[1:0]), {hi, lo});
    end
    $display("test events done");
    for (int m = 0; m < 2; m++) begin
      wr(8'h11, 4'h1);
      wr(8'h10, (m != 0) ? 4'h8 : 4'h0);
      wr(8'h12, 4'he);
      wr(8'h13, 4'hf);
      i_ptm_evsrc.pulses(3);
      rd(8'h13, hi);
      rd(8'h12, lo);
      chk("wrap", expWrap(m), {hi, lo});
      rd(8'h02, lo);
      chkBit("irqBRead", 1'b1, lo[2]);
      chkBit("toggle", m == 0, timerBOutputPin);
      wr(8'h02, 4'h4);
      chkBit("irqBClear", 1'b0, timerBIrqFlag);
    end
    chkBit("outEn", 1'b1, timerBOutputEn);
    $display("test overflow done");
    // PWM with immediate update: one 512-cycle frame holds twice the duty in highs
    wr(8'h10, 4'hf);
    wr(8'h11, 4'h4);
    rnd = nextRnd(rnd);
    wr(8'h12, rnd[3:0]);
    wr(8'h13, rnd[7:4]);
    @(posedge ref_clk);
    clkEn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    clkEn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ones = 0;
    repeat (512) begin
      @(posedge ref_clk);
      #1 ones += timerBOutputPin;
    end
    chk("pwmDuty", rnd[7:0], 8'(ones / 2));
    $display("test pwm done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
